// [hw/astx_pkg.sv]
// package of constants and types for the async serial transmitter
package astx_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned MAX_BAUD = 500000;
    localparam logic [4:0] OVERSAMPLE = 5'h10;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [7:0] PRESC_1 = 8'h01;
    localparam logic [7:0] PRESC_3 = 8'h03;
    localparam logic [7:0] PRESC_4 = 8'h04;
    localparam logic [7:0] PRESC_13 = 8'h0d;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [3:0] FRAME_8 = 4'ha;
    localparam logic [3:0] FRAME_9 = 4'hb;
    localparam logic [10:0] ALL_ONES = 11'h7ff;
    localparam logic [10:0] BREAK_WORD = 11'h000;

    typedef enum logic [4:0] {
        ASTX_OFF = 5'b00001,
        ASTX_IDLE_FRAME = 5'b00010,
        ASTX_READY = 5'b00100,
        ASTX_SHIFT = 5'b01000,
        ASTX_BREAK_END = 5'b10000
    } astx_state_t;

    typedef struct packed {
        logic transmitter_enable;
        logic receiver_enable;
        logic word_9bit;
        logic tx_ninth_bit;
        logic send_break_bit;
        logic tx_empty_irq_enable;
        logic tx_complete_irq_enable;
    } astx_ctrl_t;

    typedef struct packed {
        logic [1:0] prescale_select_field;
        logic [2:0] tx_divisor_select_field;
        logic [7:0] tx_extended_divisor;
    } astx_baud_t;
endpackage : astx_pkg

// [hw/astx_baud_gen.sv]
// transmit baud rate generator producing one tick per sixteenth of a bit
`timescale 1ns/1ps
module astx_baud_gen (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_run,
    input astx_pkg::astx_baud_t i_baud,
    output logic o_tick
);
    import astx_pkg::*;
    logic [7:0] presc_cnt;
    logic [7:0] pow_cnt;
    logic [7:0] ext_cnt;
    logic [7:0] presc_max;
    logic [7:0] pow_max;
    logic presc_tick;
    logic pow_tick;
    always_comb begin
        case (i_baud.prescale_select_field)
            2'h0: presc_max = PRESC_1 - 8'h01;
            2'h1: presc_max = PRESC_3 - 8'h01;
            2'h2: presc_max = PRESC_4 - 8'h01;
            default: presc_max = PRESC_13 - 8'h01;
        endcase
        pow_max = 8'((9'h001 << i_baud.tx_divisor_select_field) - 9'h001);
    end
    assign presc_tick = i_run && (presc_cnt == presc_max);
    assign pow_tick = presc_tick && (pow_cnt == pow_max);
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin // RQ21
        if (!i_resetn) begin
            presc_cnt <= 8'h00;
            pow_cnt <= 8'h00;
        end else if (!i_run) begin
            presc_cnt <= 8'h00;
            pow_cnt <= 8'h00;
        end else if (presc_tick) begin
            presc_cnt <= 8'h00;
            pow_cnt <= pow_tick ? 8'h00 : pow_cnt + 8'h01;
        end else begin
            presc_cnt <= presc_cnt + 8'h01;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin // RQ22
        if (!i_resetn) begin
            ext_cnt <= 8'h00;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            ext_cnt <= 8'h00;
            o_tick <= 1'b0;
        end else if (pow_tick) begin
            if (i_baud.tx_extended_divisor == 8'h00 ||
                ext_cnt == i_baud.tx_extended_divisor - 8'h01) begin
                ext_cnt <= 8'h00;
                o_tick <= 1'b1;
            end else begin
                ext_cnt <= ext_cnt + 8'h01;
                o_tick <= 1'b0;
            end
        end else begin
            o_tick <= 1'b0;
        end
    end
endmodule : astx_baud_gen

// [hw/astx_async_serial_transmitter.sv]
// transmit half of the async serial unit
`timescale 1ns/1ps
// Overview of operation
// RQ1: words are 8 or 9 data bits, picked by the word length control
// RQ2: in 9-bit mode the top data bit comes from the ninth bit control
// RQ3: data leaves on the pin least significant bit first
// RQ4: start bit drives the pin low
// RQ5: stop bit drives the pin high
// RQ6: both enables off frees the pin; otherwise an idle line is high
// RQ7: idle character is a whole frame of ones
// RQ8: enabling the transmitter takes the pin and sends one idle frame first
// RQ9: enable toggled mid-frame sends an idle frame after the current word
// RQ10: toggling the enable discards the word waiting in the holding buffer
// RQ11: software toggles enable only while the buffer empty flag is set
// RQ12: buffer empty flag sets when holding buffer empties and a frame starts
// RQ13: buffer empty interrupt request while flag and its enable are set
// RQ14: writes during a frame go to the holding buffer, loaded at frame end
// RQ15: write while not sending loads shifter, starts frame, flag sets again
// RQ16: after the stop bit the complete flag sets, with optional interrupt
// RQ17: status read then data write clears both flags; the code clears them only while the transmitter is enabled
// RQ18: send break sends all-zero frames of the word length while set
// RQ19: after break is cleared one extra one bit is sent
// RQ20: transmit rate has its own generator, up to 500K baud
// RQ21: rate is clock over 16, prescale 1/3/4/13, and power of two to 128
// RQ22: nonzero extended divisor divides further by 1 to 255, zero bypasses
// RQ23: software leaves rate settings alone while enabled
// RQ24: status read arms the clear; next data write clears the flags; the code clears them only while the transmitter is enabled
// RQ25: each bit lasts sixteen ticks of the divided baud clock
module astx_async_serial_transmitter (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input astx_pkg::astx_ctrl_t i_ctrl,
    input astx_pkg::astx_baud_t i_baud,
    input wire logic i_data_write,
    input wire logic [7:0] i_data,
    input wire logic i_status_read,
    input wire logic i_port_out,
    output logic o_pin_out,
    output logic o_pin_serial,
    output logic o_tx_buffer_empty_flag,
    output logic o_tx_complete_flag,
    output logic o_tx_empty_irq,
    output logic o_tx_complete_irq
);
    import astx_pkg::*;
    astx_state_t state;
    logic tick;
    logic [3:0] tick_cnt;
    logic [3:0] bit_cnt;
    logic [10:0] shifter;
    logic [8:0] holding;
    logic holding_full;
    logic te_prev;
    logic idle_pending;
    logic clear_armed;
    logic bit_end;
    logic frame_end;
    logic load_now;
    logic start_frame;
    logic [3:0] frame_len;
    logic [10:0] next_frame;
    logic [8:0] next_word;
    logic busy;
    logic te_rise;
    logic clear_seq;
    logic last_was_break;
    logic tx_run;

    astx_baud_gen u_baud (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_run(tx_run),
        .i_baud(i_baud),
        .o_tick(tick)
    ); // RQ20

    assign te_rise = i_ctrl.transmitter_enable && !te_prev;
    // keep the rate running so a data or break frame under way finishes when the enable drops; an idle frame stops at once
    assign tx_run = i_ctrl.transmitter_enable || busy; // RQ9
    assign bit_end = tick && (tick_cnt == TICK_LAST); // RQ25
    assign frame_len = i_ctrl.word_9bit ? FRAME_9 : FRAME_8; // RQ1
    assign frame_end = bit_end && (bit_cnt == frame_len - 4'h1);
    assign busy = (state == ASTX_SHIFT) || (state == ASTX_IDLE_FRAME) ||
                  (state == ASTX_BREAK_END);
    assign clear_seq = i_data_write && clear_armed && i_ctrl.transmitter_enable; // RQ24
    assign next_word = {i_ctrl.tx_ninth_bit, i_data}; // RQ2

    // frame image, bit 0 leaves first: start, data lsb first, optional ninth, stop
    always_comb begin
        next_frame = ALL_ONES;
        if (i_ctrl.send_break_bit) begin
            next_frame = BREAK_WORD; // RQ18
        end else if (i_ctrl.word_9bit) begin
            next_frame = {1'b1, (holding_full ? holding : next_word), 1'b0}; // RQ3 RQ4 RQ5
        end else begin
            next_frame = {2'b11, (holding_full ? holding[7:0] : next_word[7:0]), 1'b0};
        end
    end
    assign load_now = (state == ASTX_READY) && (holding_full || i_ctrl.send_break_bit);
    assign start_frame = load_now || ((state == ASTX_READY) && i_data_write); // RQ15

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            te_prev <= 1'b0;
        end else begin
            te_prev <= i_ctrl.transmitter_enable;
        end
    end

    // sequencing of idle, data and break frames
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ASTX_OFF;
            tick_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            shifter <= ALL_ONES;
            idle_pending <= 1'b0;
        end else begin
            if (tick) begin
                tick_cnt <= tick_cnt + 4'h1;
            end
            if (bit_end) begin
                bit_cnt <= bit_cnt + 4'h1;
                shifter <= {1'b1, shifter[10:1]}; // RQ3
            end
            if (te_rise && (state == ASTX_SHIFT)) begin
                idle_pending <= 1'b1; // RQ9
            end
            case (state)
                ASTX_OFF: begin
                    shifter <= ALL_ONES;
                    if (i_ctrl.transmitter_enable) begin
                        state <= ASTX_IDLE_FRAME; // RQ8
                        tick_cnt <= 4'h0;
                        bit_cnt <= 4'h0;
                    end
                end
                ASTX_IDLE_FRAME: begin
                    shifter <= ALL_ONES; // RQ7
                    if (!i_ctrl.transmitter_enable) begin
                        state <= ASTX_OFF;
                    end else if (frame_end) begin
                        state <= ASTX_READY;
                    end
                end
                ASTX_READY: begin
                    shifter <= ALL_ONES;
                    tick_cnt <= 4'h0;
                    bit_cnt <= 4'h0;
                    if (!i_ctrl.transmitter_enable) begin
                        state <= ASTX_OFF;
                    end else if (start_frame) begin
                        shifter <= next_frame; // RQ14
                        state <= ASTX_SHIFT;
                    end
                end
                ASTX_SHIFT: begin
                    if (frame_end) begin
                        tick_cnt <= 4'h0;
                        bit_cnt <= 4'h0;
                        if (idle_pending) begin
                            idle_pending <= 1'b0;
                            state <= ASTX_IDLE_FRAME;
                        end else if (i_ctrl.send_break_bit) begin
                            shifter <= BREAK_WORD; // RQ18
                        end else if (last_was_break) begin
                            shifter <= ALL_ONES;
                            state <= ASTX_BREAK_END; // RQ19
                        end else begin
                            state <= ASTX_READY;
                        end
                    end
                end
                ASTX_BREAK_END: begin
                    shifter <= ALL_ONES;
                    if (bit_end) begin
                        tick_cnt <= 4'h0;
                        bit_cnt <= 4'h0;
                        state <= ASTX_READY;
                    end
                end
                default: begin
                    state <= ASTX_OFF;
                end
            endcase
        end
    end

    // break tracking: a break frame just finished while break is now clear
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last_was_break <= 1'b0;
        end else if (state == ASTX_READY && start_frame) begin
            last_was_break <= i_ctrl.send_break_bit;
        end else if (state == ASTX_SHIFT && frame_end) begin
            last_was_break <= i_ctrl.send_break_bit;
        end
    end

    // holding buffer
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            holding <= 9'h000;
            holding_full <= 1'b0;
        end else if (te_rise) begin
            holding_full <= 1'b0; // RQ10
        end else if (i_data_write && i_ctrl.transmitter_enable && state != ASTX_READY) begin
            holding <= next_word; // RQ14
            holding_full <= 1'b1;
        end else if (load_now && !i_ctrl.send_break_bit) begin
            holding_full <= 1'b0;
        end
    end

    // status flags and the clear sequence
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            clear_armed <= 1'b0;
            o_tx_buffer_empty_flag <= 1'b1;
            o_tx_complete_flag <= 1'b1;
        end else begin
            if (i_status_read) begin
                clear_armed <= 1'b1; // RQ24
            end else if (i_data_write) begin
                clear_armed <= 1'b0;
            end
            if ((start_frame && !i_ctrl.send_break_bit) || te_rise) begin
                o_tx_buffer_empty_flag <= 1'b1; // RQ12 RQ15
            end else if (clear_seq) begin
                o_tx_buffer_empty_flag <= 1'b0; // RQ17
            end
            if (state == ASTX_SHIFT && frame_end && !last_was_break) begin
                o_tx_complete_flag <= 1'b1; // RQ16
            end else if (clear_seq) begin
                o_tx_complete_flag <= 1'b0; // RQ17
            end
        end
    end

    // pin drive and interrupt requests
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pin_out <= 1'b1;
            o_pin_serial <= 1'b0;
            o_tx_empty_irq <= 1'b0;
            o_tx_complete_irq <= 1'b0;
        end else begin
            o_pin_serial <= i_ctrl.transmitter_enable || i_ctrl.receiver_enable; // RQ6
            if (!(i_ctrl.transmitter_enable || i_ctrl.receiver_enable)) begin
                o_pin_out <= i_port_out; // RQ6
            end else if (busy) begin
                o_pin_out <= shifter[0];
            end else begin
                o_pin_out <= 1'b1; // RQ6
            end
            o_tx_empty_irq <= o_tx_buffer_empty_flag && i_ctrl.tx_empty_irq_enable; // RQ13
            o_tx_complete_irq <= o_tx_complete_flag && i_ctrl.tx_complete_irq_enable; // RQ16
        end
    end
endmodule : astx_async_serial_transmitter

// [tb/astx_line_rx.sv]
// line receiver model that decodes frames from the transmit pin
`timescale 1ns/1ps
module astx_line_rx (
    input wire logic i_ref_clk,
    input wire logic i_pin,
    input wire logic i_serial,
    input wire logic i_nine,
    input wire logic [15:0] i_bit,
    output logic o_busy = 1'b0,
    output logic o_got = 1'b0,
    output logic [10:0] o_frame = '0
);
    int n;
    always begin
        @(negedge i_pin);
        #1;
        if (i_serial === 1'b1) begin
            o_busy = 1'b1;
            repeat (i_bit / 2) @(posedge i_ref_clk);
            o_frame = {i_pin, 10'h000};
            for (n = 0; n < (i_nine ? 10 : 9); n++) begin
                repeat (i_bit) @(posedge i_ref_clk);
                o_frame[n == (i_nine ? 9 : 8) ? 9 : n] = i_pin;
            end
            @(negedge i_ref_clk);
            o_busy = 1'b0;
            o_got = 1'b1;
            @(negedge i_ref_clk);
            o_got = 1'b0;
        end
    end
endmodule : astx_line_rx

// [tb/astx_tx_props.sv]
// assertion checker for the transmitter ports
`timescale 1ns/1ps
module astx_tx_props (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input astx_pkg::astx_ctrl_t i_ctrl,
    input astx_pkg::astx_baud_t i_baud,
    input wire logic i_data_write,
    input wire logic i_status_read,
    input wire logic i_port_out,
    input wire logic o_pin_out,
    input wire logic o_pin_serial,
    input wire logic o_tx_buffer_empty_flag,
    input wire logic o_tx_complete_flag,
    input wire logic o_tx_empty_irq,
    input wire logic o_tx_complete_irq
);
    import astx_pkg::*;
    logic armed;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            armed <= 1'b0;
        end else if (i_status_read || i_data_write) begin
            armed <= i_status_read;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    AST_PORT_FREE: assert property (!i_ctrl.transmitter_enable && !i_ctrl.receiver_enable
        |=> !o_pin_serial && o_pin_out == $past(i_port_out)) else $error("pin not freed");
    AST_SERIAL_OWN: assert property (i_ctrl.transmitter_enable || i_ctrl.receiver_enable
        |=> o_pin_serial) else $error("pin not taken");
    AST_EMPTY_IRQ: assert property (o_tx_empty_irq ==
        $past(o_tx_buffer_empty_flag && i_ctrl.tx_empty_irq_enable))
        else $error("empty irq wrong");
    AST_DONE_IRQ: assert property (o_tx_complete_irq ==
        $past(o_tx_complete_flag && i_ctrl.tx_complete_irq_enable))
        else $error("complete irq wrong");
    AST_CLEAR: assert property (armed && i_data_write && i_ctrl.transmitter_enable
        |=> !o_tx_complete_flag) else $error("complete flag not cleared");
    AST_KEEP: assert property (!armed && !i_status_read && i_data_write
        && o_tx_complete_flag |=> o_tx_complete_flag) else $error("flag cleared unarmed");
    AST_REFUSE: assert property (!i_ctrl.transmitter_enable && i_data_write
        && o_tx_buffer_empty_flag |=> o_tx_buffer_empty_flag) else $error("write not refused");
    AST_BIT_HOLD: assert property (i_baud == '0 && o_pin_serial && $past(o_pin_serial)
        && $changed(o_pin_out) |=> $stable(o_pin_out)[*8]) else $error("bit too short");
endmodule : astx_tx_props
bind astx_async_serial_transmitter astx_tx_props u_astx_tx_props (.i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn), .i_ctrl(i_ctrl), .i_baud(i_baud), .i_data_write(i_data_write),
    .i_status_read(i_status_read), .i_port_out(i_port_out), .o_pin_out(o_pin_out),
    .o_pin_serial(o_pin_serial), .o_tx_buffer_empty_flag(o_tx_buffer_empty_flag),
    .o_tx_complete_flag(o_tx_complete_flag), .o_tx_empty_irq(o_tx_empty_irq),
    .o_tx_complete_irq(o_tx_complete_irq));

// [tb/tb_top.sv]
// self-checking testbench for the transmitter
`timescale 1ns/1ps
module tb_top;
    import astx_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    astx_ctrl_t ctrl = '0;
    astx_baud_t baud = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic port = 1'b0;
    logic [7:0] data = 8'h00;
    logic pin, serial, emp, done, emp_irq, done_irq, busy, got;
    logic [10:0] frame;
    logic [15:0] bit_cyc = 16'h0010;
    logic [10:0] exp_q[$];
    astx_baud_t cfgs[4] = '{13'h0000, 13'h0900, 13'h1003, 13'h1801};
    logic [15:0] cycs[4] = '{16'h0010, 16'h0060, 16'h00c0, 16'h00d0};
    int err_total = 0;
    int num_checks = 0;
    int seed = 78;
    int cyc = 0;
    int t0;
    int i;
    astx_async_serial_transmitter u_astx_async_serial_transmitter (.i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn), .i_ctrl(ctrl), .i_baud(baud), .i_data_write(wr), .i_data(data),
        .i_status_read(rd), .i_port_out(port), .o_pin_out(pin), .o_pin_serial(serial),
        .o_tx_buffer_empty_flag(emp), .o_tx_complete_flag(done), .o_tx_empty_irq(emp_irq),
        .o_tx_complete_irq(done_irq));
    astx_line_rx u_astx_line_rx (.i_ref_clk(i_ref_clk), .i_pin(pin), .i_serial(serial),
        .i_nine(ctrl.word_9bit), .i_bit(bit_cyc), .o_busy(busy), .o_got(got), .o_frame(frame));
    always #50 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic send(input logic [8:0] w, input bit keep, input bit arm);
        @(negedge i_ref_clk);
        rd = arm;
        ctrl.tx_ninth_bit = w[8];
        @(negedge i_ref_clk);
        rd = 1'b0;
        wr = 1'b1;
        data = w[7:0];
        if (keep) exp_q.push_back({2'b01, ctrl.word_9bit & w[8], w[7:0]});
        @(negedge i_ref_clk);
        wr = 1'b0;
    endtask : send
    task automatic wait_idle;
        for (int k = 0; k < 20000 && (exp_q.size() != 0 || busy === 1'b1); k++)
            @(negedge i_ref_clk);
        repeat (bit_cyc) @(negedge i_ref_clk);
        check("drained", 11'(exp_q.size()), 11'h000);
    endtask : wait_idle
    task automatic wait_start;
        for (int k = 0; k < 20000 && busy !== 1'b1; k++)
            @(negedge i_ref_clk);
        check("started", 11'(busy), 11'h001);
    endtask : wait_start
    task automatic set_rate(input int n);
        ctrl.transmitter_enable = 1'b0;
        ctrl.receiver_enable = 1'b0;
        @(negedge i_ref_clk);
        baud = cfgs[n];
        bit_cyc = cycs[n];
        @(negedge i_ref_clk);
        ctrl.transmitter_enable = 1'b1;
        ctrl.receiver_enable = 1'b1;
        t0 = cyc;
    endtask : set_rate
    always @(posedge i_ref_clk) begin
        if (got === 1'b1) begin
            if (exp_q.size() == 0) check("extra frame", frame, 11'h7ff);
            else check("frame", frame, exp_q.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_resetn = 1'b1;
        port = 1'($random(seed));
        rd = 1'b1;
        @(negedge i_ref_clk);
        rd = 1'b0;
        wr = 1'b1;
        @(negedge i_ref_clk);
        wr = 1'b0;
        check("empty", {emp, done}, 2'b11);
        @(negedge i_ref_clk);
        check("port", {serial, pin}, {1'b0, port});
        for (i = 0; i < 4; i++) begin
            ctrl.word_9bit = i[0];
            set_rate(i);
            send(9'($random(seed)), 1'b1, 1'b1);
            wait_start;
            check("idle", 11'((cyc - t0) >= (i[0] ? 11 : 10) * bit_cyc), 1'b1);
            wait_idle;
            check("complete", done, 1'b1);
        end
        ctrl.word_9bit = 1'b0;
        set_rate(0);
        repeat (200) @(negedge i_ref_clk);
        send(9'h0a5, 1'b1, 1'b1);
        send(9'h13c, 1'b1, 1'b1);
        check("held", emp, 1'b0);
        wait_idle;
        check("empty again", {emp, done}, 2'b11);
        send(9'h0c3, 1'b1, 1'b0);
        check("kept", done, 1'b1);
        wait_idle;
        send(9'h03c, 1'b1, 1'b1);
        check("cleared", done, 1'b0);
        send(9'h0ff, 1'b0, 1'b1);
        ctrl.transmitter_enable = 1'b0;
        @(negedge i_ref_clk);
        ctrl.transmitter_enable = 1'b1;
        for (int k = 0; k < 2000 && exp_q.size() != 0; k++)
            @(negedge i_ref_clk);
        t0 = cyc;
        send(9'h081, 1'b1, 1'b1);
        wait_start;
        check("idle after", 11'((cyc - t0) >= 9 * bit_cyc), 1'b1);
        wait_idle;
        exp_q.push_back(11'h000);
        ctrl.send_break_bit = 1'b1;
        repeat (250) @(negedge i_ref_clk);
        ctrl.send_break_bit = 1'b0;
        send(9'h05a, 1'b1, 1'b1);
        wait_idle;
        check("after break", {emp, done}, 2'b11);
        for (i = 0; i < 6; i++) begin
            ctrl.word_9bit = (i > 3);
            ctrl.tx_empty_irq_enable = 1'($random(seed));
            ctrl.tx_complete_irq_enable = 1'($random(seed));
            send(9'($random(seed)), 1'b1, 1'b1);
            wait_idle;
            check("empty irq", emp_irq, ctrl.tx_empty_irq_enable);
            check("done irq", done_irq, ctrl.tx_complete_irq_enable);
        end
        ctrl.transmitter_enable = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        check("rx only", {serial, pin}, 2'b11);
        ctrl.receiver_enable = 1'b0;
        port = ~port;
        repeat (2) @(negedge i_ref_clk);
        check("port back", {serial, pin}, {1'b0, port});
        test_done;
    end
endmodule : tb_top
